/* verilog/ee_pkg.sv */
// Overview of operation
// - ignore the bus until a START
// - STOP is SDA rising with SCL high
// - SDA change while SCL high is START/STOP
// - accept address byte only with code 1010
// - receiver acknowledges in the ninth clock
// - acknowledge every byte when written to
// - read: send byte, continue only on acknowledge
// - byte write loads word address, then data
// - STOP after data starts programming, bus ignored
// - page write advances only low four address bits
// - more than sixteen bytes wrap inside page
// - whole page programmed in one cycle
// - address acknowledged again once programming ends
// - write protect refuses first data byte
// - counter holds last address plus one
// - address counter wraps after 2047 to zero
// - current read sends one byte, then STOP
// - random read: dummy write, then read
// - each master acknowledge sends next byte
// - manual reset sensed on active edge only
// - sensed edge holds opposite reset for 200ms
// - no acknowledge while any reset is present
// - programming cycle ends within 10 ms
package ee_pkg;

  ////////////////////////////////////////////////////////////
  // clocks and timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned LINK_HZ = 166_666_667;
  localparam int unsigned SCL_HZ = 100_000;
  localparam int unsigned QTR_CYC = CLK_HZ / (4 * SCL_HZ);
  localparam int unsigned RST_HOLD_MS = 200;
  localparam int unsigned PROG_MS = 10;
  // least time rounds up, longest time rounds down
  localparam int unsigned RST_HOLD_CYC = RST_HOLD_MS * ((LINK_HZ + 999) / 1000);
  localparam int unsigned PROG_CYC = PROG_MS * (LINK_HZ / 1000);

  ////////////////////////////////////////////////////////////
  // address byte and array layout
  localparam logic [3:0] DEV_CODE = 4'hA;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned PAGE_W = 4;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] ACK_END = 4'h9;

  ////////////////////////////////////////////////////////////
  // host command set
  typedef enum logic [1:0] {
    EE_CMD_START,
    EE_CMD_STOP,
    EE_CMD_WRITE,
    EE_CMD_READ
  } ee_cmd_t;

endpackage : ee_pkg

/* verilog/ee_bus_if.sv */
`timescale 1ns/1ps
interface ee_bus_if;
  // serial clock, driven low by the master only
  logic scl_o;
  logic scl_oe;
  logic scl;
  // serial data, open drain at both ends
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic sda;
  // active-high reset pin, pulled down
  logic rhi_h_o;
  logic rhi_h_oe;
  logic rhi_d_o;
  logic rhi_d_oe;
  logic rst_hi;
  // active-low reset pin, pulled up
  logic rlo_h_o;
  logic rlo_h_oe;
  logic rlo_d_o;
  logic rlo_d_oe;
  logic rst_lo_n;
  // write protect strap
  logic wp;

  assign scl = !(scl_oe && !scl_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  assign rst_hi = (rhi_h_oe && rhi_h_o) || (rhi_d_oe && rhi_d_o);
  assign rst_lo_n = !((rlo_h_oe && !rlo_h_o) || (rlo_d_oe && !rlo_d_o));

  modport dev (
    input scl, sda, rst_hi, rst_lo_n, wp,
    output sda_s_o, sda_s_oe, rhi_d_o, rhi_d_oe, rlo_d_o, rlo_d_oe
  );
  modport host (
    input sda, rst_hi, rst_lo_n,
    output scl_o, scl_oe, sda_m_o, sda_m_oe, rhi_h_o, rhi_h_oe, rlo_h_o, rlo_h_oe, wp
  );
endinterface : ee_bus_if

/* verilog/ee_host.sv */
`timescale 1ns/1ps
module ee_host #(
  parameter int unsigned QTR_CYC = ee_pkg::QTR_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // serial bus
  ee_bus_if.host bus,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire ee_pkg::ee_cmd_t cmd_kind,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ack_send,
  // answer
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack,
  // pins
  input wire logic mr_hi_req,
  input wire logic mr_lo_req,
  input wire logic wp_req
);

  typedef enum logic [1:0] {H_IDLE, H_START, H_STOP, H_BYTE} ee_hst_t;

  ee_hst_t st_r;
  ee_pkg::ee_cmd_t kind_r;
  logic [7:0] dat_r;
  logic ack_send_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [15:0] q_r;
  logic scl_lo_r;
  logic sda_lo_r;
  logic [1:0] sda_sy;
  logic tick;
  logic bit_lo;
  logic [2:0] idx;

  ////////////////////////////////////////////////////////////
  // pins
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_lo_r;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = sda_lo_r;
  assign bus.rhi_h_o = 1'b1;
  assign bus.rlo_h_o = 1'b0;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus.rhi_h_oe <= 1'b0;
      bus.rlo_h_oe <= 1'b0;
      bus.wp <= 1'b0;
    end else begin
      bus.rhi_h_oe <= mr_hi_req;
      bus.rlo_h_oe <= mr_lo_req;
      bus.wp <= wp_req;
    end
  end

  // data line comes from the other party
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sda_sy <= 2'h3;
    end else begin
      sda_sy <= {sda_sy[0], bus.sda};
    end
  end

  ////////////////////////////////////////////////////////////
  // quarter-bit timer
  assign tick = (q_r == 16'(QTR_CYC - 1));

  always_ff @(posedge ref_clk) begin
    if (reset || st_r == H_IDLE || tick) begin
      q_r <= 16'h0;
    end else begin
      q_r <= q_r + 16'h1;
    end
  end

  assign idx = 3'h7 - bit_r[2:0];
  always_comb begin
    if (bit_r == ee_pkg::ACK_SLOT) begin
      bit_lo = (kind_r == ee_pkg::EE_CMD_READ) && ack_send_r;
    end else begin
      bit_lo = (kind_r == ee_pkg::EE_CMD_WRITE) && !dat_r[idx];
    end
  end

  ////////////////////////////////////////////////////////////
  // bit sequencer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= H_IDLE;
      kind_r <= ee_pkg::EE_CMD_STOP;
      dat_r <= 8'h00;
      ack_send_r <= 1'b0;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      scl_lo_r <= 1'b0;
      sda_lo_r <= 1'b0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_ack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (st_r)
        H_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            kind_r <= cmd_kind;
            dat_r <= cmd_data;
            ack_send_r <= cmd_ack_send;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            if (cmd_kind == ee_pkg::EE_CMD_START) begin
              st_r <= H_START;
            end else if (cmd_kind == ee_pkg::EE_CMD_STOP) begin
              st_r <= H_STOP;
            end else begin
              st_r <= H_BYTE;
            end
          end
        end
        H_START: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_lo_r <= 1'b0;
              2'h1: scl_lo_r <= 1'b0;
              2'h2: sda_lo_r <= 1'b1;
              default: begin
                scl_lo_r <= 1'b1;
                st_r <= H_IDLE;
                cmd_ready <= 1'b1;
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_lo_r <= 1'b1;
              2'h1: scl_lo_r <= 1'b0;
              2'h2: sda_lo_r <= 1'b0;
              default: begin
                st_r <= H_IDLE;
                cmd_ready <= 1'b1;
              end
            endcase
          end
        end
        default: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              // data changes only while the clock is low
              2'h0: sda_lo_r <= bit_lo;
              2'h1: scl_lo_r <= 1'b0;
              2'h2: begin
                if (bit_r == ee_pkg::ACK_SLOT) begin
                  rsp_ack <= !sda_sy[1];
                end else begin
                  rsp_data <= {rsp_data[6:0], sda_sy[1]};
                end
              end
              default: begin
                scl_lo_r <= 1'b1;
                if (bit_r == ee_pkg::ACK_SLOT) begin
                  st_r <= H_IDLE;
                  cmd_ready <= 1'b1;
                  rsp_valid <= 1'b1;
                end else begin
                  bit_r <= bit_r + 4'h1;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

endmodule : ee_host

/* verilog/ee_dev.sv */
`timescale 1ns/1ps
module ee_dev #(
  parameter int unsigned RST_HOLD_CYC = ee_pkg::RST_HOLD_CYC,
  parameter int unsigned PROG_CYC = ee_pkg::PROG_CYC,
  parameter int unsigned AW = ee_pkg::ADDR_W,
  parameter int unsigned PW = ee_pkg::PAGE_W
) (
  // link clock and its reset
  input wire logic link_clk,
  input wire logic reset,
  // serial bus
  ee_bus_if.dev bus,
  // status
  output logic prog_busy,
  output logic reset_hold
);

  typedef enum logic [2:0] {S_IDLE, S_DEV, S_WORD, S_DATA, S_RD, S_HOLD} ee_dst_t;

  localparam int unsigned PAGE_N = 1 << PW;

  ee_dst_t st_r;
  logic [1:0] scl_sy;
  logic [1:0] sda_sy;
  logic [1:0] rhi_sy;
  logic [1:0] rlo_sy;
  logic [1:0] wp_sy;
  logic scl_p;
  logic sda_p;
  logic rhi_p;
  logic rlo_p;
  logic scl_s;
  logic sda_s;
  logic rhi_s;
  logic rlo_s;
  logic wp_s;
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;
  logic mr_edge;
  logic disabled;
  logic commit;
  logic [31:0] hold_cnt_r;
  logic [31:0] prog_cnt_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic [2:0] idx;
  logic [AW-1:0] ptr_r;
  logic [2:0] hib_r;
  logic pend_r;
  logic mack_r;
  logic sda_oe_r;
  logic [PAGE_N-1:0] mask_r;
  logic [7:0] pbuf [PAGE_N];
  logic [7:0] mem [1 << AW];

  ////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge link_clk) begin
    if (reset) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      rhi_sy <= 2'h0;
      rlo_sy <= 2'h3;
      wp_sy <= 2'h0;
    end else begin
      scl_sy <= {scl_sy[0], bus.scl};
      sda_sy <= {sda_sy[0], bus.sda};
      rhi_sy <= {rhi_sy[0], bus.rst_hi};
      rlo_sy <= {rlo_sy[0], bus.rst_lo_n};
      wp_sy <= {wp_sy[0], bus.wp};
    end
  end

  assign scl_s = scl_sy[1];
  assign sda_s = sda_sy[1];
  assign rhi_s = rhi_sy[1];
  assign rlo_s = rlo_sy[1];
  assign wp_s = wp_sy[1];

  always_ff @(posedge link_clk) begin
    if (reset) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      rhi_p <= 1'b0;
      rlo_p <= 1'b1;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
      rhi_p <= rhi_s;
      rlo_p <= rlo_s;
    end
  end

  // data moving under a high clock is a condition, never a bit
  assign start_ev = scl_s && scl_p && sda_p && !sda_s;
  assign stop_ev = scl_s && scl_p && !sda_p && sda_s;
  assign scl_rise = scl_s && !scl_p;
  assign scl_fall = !scl_s && scl_p;

  ////////////////////////////////////////////////////////////
  // manual reset; edges are blind while we drive the pins ourselves
  assign mr_edge = !reset_hold && ((rhi_s && !rhi_p) || (!rlo_s && rlo_p));

  always_ff @(posedge link_clk) begin
    if (reset) begin
      hold_cnt_r <= 32'h0;
      reset_hold <= 1'b0;
    end else if (mr_edge) begin
      hold_cnt_r <= RST_HOLD_CYC - 1;
      reset_hold <= 1'b1;
    end else if (hold_cnt_r != 32'h0) begin
      hold_cnt_r <= hold_cnt_r - 32'h1;
      // full count of cycles, the last one included
      reset_hold <= 1'b1;
    end else begin
      reset_hold <= 1'b0;
    end
  end

  assign bus.rhi_d_o = 1'b1;
  assign bus.rlo_d_o = 1'b0;
  assign bus.rhi_d_oe = reset_hold;
  assign bus.rlo_d_oe = reset_hold;

  // a pin still forced after the hold keeps the array shut
  assign disabled = reset_hold || rhi_s || !rlo_s || prog_busy;

  ////////////////////////////////////////////////////////////
  // programming cycle
  assign commit = stop_ev && pend_r;

  always_ff @(posedge link_clk) begin
    if (reset) begin
      prog_cnt_r <= 32'h0;
      prog_busy <= 1'b0;
    end else if (commit) begin
      prog_cnt_r <= PROG_CYC - 1;
      prog_busy <= 1'b1;
    end else if (prog_cnt_r != 32'h0) begin
      prog_cnt_r <= prog_cnt_r - 32'h1;
      prog_busy <= (prog_cnt_r != 32'h1);
    end else begin
      prog_busy <= 1'b0;
    end
  end

  // all buffered bytes land in one step; ptr high bits are the page
  always_ff @(posedge link_clk) begin
    if (commit) begin
      for (int i = 0; i < PAGE_N; i++) begin
        if (mask_r[i]) begin
          mem[{ptr_r[AW-1:PW], PW'(i)}] <= pbuf[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // bus protocol
  assign idx = 3'h7 - bit_cnt_r[2:0];
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = sda_oe_r;

  always_ff @(posedge link_clk) begin
    if (reset) begin
      st_r <= S_IDLE;
      bit_cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= '0;
      hib_r <= 3'h0;
      pend_r <= 1'b0;
      mack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      mask_r <= '0;
    end else if (start_ev) begin
      // a repeated START drops unfinished page data
      st_r <= S_DEV;
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
      pend_r <= 1'b0;
    end else if (stop_ev) begin
      st_r <= S_IDLE;
      sda_oe_r <= 1'b0;
      pend_r <= 1'b0;
    end else if (st_r == S_IDLE || st_r == S_HOLD) begin
      sda_oe_r <= 1'b0;
    end else if (scl_rise) begin
      if (bit_cnt_r < ee_pkg::ACK_SLOT) begin
        sh_r <= {sh_r[6:0], sda_s};
      end else if (st_r == S_RD && bit_cnt_r == ee_pkg::ACK_SLOT) begin
        mack_r <= !sda_s;
      end
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end else if (scl_fall) begin
      if (bit_cnt_r == ee_pkg::ACK_SLOT) begin
        sda_oe_r <= 1'b0;
        if (st_r != S_RD && disabled) begin
          st_r <= S_HOLD;
        end else begin
          case (st_r)
            S_DEV: begin
              if (sh_r[7:4] == ee_pkg::DEV_CODE) begin
                sda_oe_r <= 1'b1;
                hib_r <= sh_r[3:1];
                if (sh_r[0]) begin
                  st_r <= S_RD;
                  mack_r <= 1'b1;
                  ptr_r[AW-1:AW-3] <= sh_r[3:1];
                end else begin
                  st_r <= S_WORD;
                end
              end else begin
                st_r <= S_HOLD;
              end
            end
            S_WORD: begin
              ptr_r <= {hib_r, sh_r};
              mask_r <= '0;
              sda_oe_r <= 1'b1;
              st_r <= S_DATA;
            end
            S_DATA: begin
              if (wp_s) begin
                // nothing of this transfer may reach the array
                st_r <= S_HOLD;
                mask_r <= '0;
              end else begin
                sda_oe_r <= 1'b1;
                pbuf[ptr_r[PW-1:0]] <= sh_r;
                mask_r[ptr_r[PW-1:0]] <= 1'b1;
                // the page part wraps, overwriting earlier bytes
                ptr_r[PW-1:0] <= ptr_r[PW-1:0] + PW'(1);
                pend_r <= 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end else if (bit_cnt_r == ee_pkg::ACK_END) begin
        bit_cnt_r <= 4'h0;
        if (st_r == S_RD && mack_r) begin
          tx_r <= mem[ptr_r];
          sda_oe_r <= !mem[ptr_r][7];
          // full width counter wraps from the top address to zero
          ptr_r <= ptr_r + AW'(1);
        end else if (st_r == S_RD) begin
          st_r <= S_HOLD;
          sda_oe_r <= 1'b0;
        end else begin
          sda_oe_r <= 1'b0;
        end
      end else if (st_r == S_RD) begin
        sda_oe_r <= !tx_r[idx];
      end
    end
  end

endmodule : ee_dev

/* sim/ee_props.sv */
`timescale 1ns/1ps
module ee_props #(
  parameter int unsigned RST_HOLD_CYC = 200,
  parameter int unsigned PROG_CYC = 50
) (
  // link clock and reset
  input wire logic link_clk,
  input wire logic reset,
  // bus lines
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_oe,
  input wire logic rst_hi,
  input wire logic rst_lo_n,
  input wire logic rhi_d_oe,
  input wire logic rlo_d_oe,
  // device status
  input wire logic prog_busy,
  input wire logic reset_hold
);
  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////
  logic started_r;
  logic [31:0] hold_cnt_r;
  logic [31:0] prog_cnt_r;

  always_ff @(posedge link_clk) begin
    if (reset) started_r <= 1'h0;
    else if ($fell(sda) && scl) started_r <= 1'h1;
  end

  always_ff @(posedge link_clk) begin
    if (reset || !reset_hold) hold_cnt_r <= 32'h0;
    else hold_cnt_r <= hold_cnt_r + 32'h1;
  end

  always_ff @(posedge link_clk) begin
    if (reset || !prog_busy) prog_cnt_r <= 32'h0;
    else prog_cnt_r <= prog_cnt_r + 32'h1;
  end

  ////////////////////////////////
  sequence s_pins_on;
    ##[0:2] (rhi_d_oe && rlo_d_oe);
  endsequence
  sequence s_hold_off;
    ##1 !reset_hold [*8];
  endsequence

  // sync lag of the device is a few cycles, so five settled cycles suffice
  property p_quiet_before_start;
    !started_r |-> !sda_s_oe;
  endproperty
  property p_stable_high;
    $changed(sda_s_oe) |-> !scl;
  endproperty
  property p_busy_quiet;
    prog_busy [*5] |-> !$rose(sda_s_oe);
  endproperty
  property p_prog_bound;
    prog_busy |-> prog_cnt_r <= PROG_CYC;
  endproperty
  property p_reset_quiet;
    (rst_hi || !rst_lo_n) [*5] |-> !$rose(sda_s_oe);
  endproperty
  property p_edge_starts;
    ($rose(rst_hi) || $fell(rst_lo_n)) && !reset_hold |-> ##[1:8] reset_hold;
  endproperty
  property p_hold_pins;
    $rose(reset_hold) |-> s_pins_on;
  endproperty
  property p_hold_len;
    $fell(reset_hold) |-> hold_cnt_r >= RST_HOLD_CYC - 1 && hold_cnt_r <= RST_HOLD_CYC + 1;
  endproperty
  property p_no_retrigger;
    $fell(reset_hold) |-> s_hold_off;
  endproperty

  a_quiet_before_start: assert property (p_quiet_before_start) else $error("sda driven before start");
  a_stable_high: assert property (p_stable_high) else $error("sda drive changed with scl high");
  a_busy_quiet: assert property (p_busy_quiet) else $error("ack while programming");
  a_prog_bound: assert property (p_prog_bound) else $error("programming too long");
  a_reset_quiet: assert property (p_reset_quiet) else $error("ack while reset present");
  a_edge_starts: assert property (p_edge_starts) else $error("reset edge not sensed");
  a_hold_pins: assert property (p_hold_pins) else $error("reset pins not driven in hold");
  a_hold_len: assert property (p_hold_len) else $error("reset hold length wrong");
  a_no_retrigger: assert property (p_no_retrigger) else $error("hold retriggered by level");
endmodule : ee_props

/* sim/ee_test.sv */
`timescale 1ns/1ps
module ee_test;
  localparam int unsigned HOLD = 3000;
  localparam int unsigned PROG = 3000;
  logic ref_clk = 1'h0;
  logic link_clk = 1'h0;
  logic reset = 1'h1;
  logic cmd_valid = 1'h0;
  ee_pkg::ee_cmd_t cmd_kind = ee_pkg::EE_CMD_START;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ack_send = 1'h0;
  logic mr_hi_req = 1'h0;
  logic mr_lo_req = 1'h0;
  logic wp_req = 1'h0;
  logic cmd_ready;
  logic rsp_valid;
  logic rsp_ack;
  logic prog_busy;
  logic reset_hold;
  logic [7:0] rsp_data;
  int fails = 0;
  int cmp_count = 0;
  int byte_n = 0;
  int rsp_n = 0;
  logic [7:0] mem [0:2047];
  logic [10:0] row_a [4] = '{11'h000, 11'h2A5, 11'h5C3, 11'h7FF};
  logic [7:0] row_d [4] = '{8'h3C, 8'hA5, 8'h5A, 8'hC3};

  ee_bus_if bus();
  ee_dev #(.RST_HOLD_CYC(HOLD), .PROG_CYC(PROG)) u_ee_dev (.link_clk(link_clk), .reset(reset),
    .bus(bus.dev), .prog_busy(prog_busy), .reset_hold(reset_hold));
  ee_host #(.QTR_CYC(8)) u_ee_host (.ref_clk(ref_clk), .reset(reset), .bus(bus.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_data(cmd_data),
    .cmd_ack_send(cmd_ack_send), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack),
    .mr_hi_req(mr_hi_req), .mr_lo_req(mr_lo_req), .wp_req(wp_req));
  ee_props #(.RST_HOLD_CYC(HOLD), .PROG_CYC(PROG)) u_ee_props (.link_clk(link_clk), .reset(reset),
    .scl(bus.scl), .sda(bus.sda), .sda_s_oe(bus.sda_s_oe), .rst_hi(bus.rst_hi), .rst_lo_n(bus.rst_lo_n),
    .rhi_d_oe(bus.rhi_d_oe), .rlo_d_oe(bus.rlo_d_oe), .prog_busy(prog_busy), .reset_hold(reset_hold));

  always #20 ref_clk = ~ref_clk;
  // edges meet the reference clock edges once every 60 ns
  always #3 link_clk = ~link_clk;

  // one answer pulse per byte command
  always @(posedge ref_clk) begin
    if (rsp_valid === 1'h1) begin
      rsp_n <= rsp_n + 1;
    end
  end

  ////////////////////////////////
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte

  task cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: bit %h expected %h", $time, got, exp);
    end
  endtask : cmp_bit

  task cmp_num(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: count %h expected %h", $time, got, exp);
    end
  endtask : cmp_num

  // entered only just after a clock edge
  task op(input ee_pkg::ee_cmd_t k, input logic [7:0] d, input logic a);
    if (k == ee_pkg::EE_CMD_WRITE || k == ee_pkg::EE_CMD_READ) byte_n++;
    while (cmd_ready !== 1'h1) @(posedge ref_clk);
    cmd_valid <= 1'h1;
    cmd_kind <= k;
    cmd_data <= d;
    cmd_ack_send <= a;
    @(posedge ref_clk);
    cmd_valid <= 1'h0;
    @(posedge ref_clk);
    while (cmd_ready !== 1'h1) @(posedge ref_clk);
  endtask : op

  task wr(input logic [7:0] d);
    op(ee_pkg::EE_CMD_WRITE, d, 1'h0);
  endtask : wr

  task sp;
    op(ee_pkg::EE_CMD_STOP, 8'h00, 1'h0);
  endtask : sp

  task dev(input logic [10:0] a, input logic r);
    op(ee_pkg::EE_CMD_START, 8'h00, 1'h0);
    wr({ee_pkg::DEV_CODE, a[10:8], r});
  endtask : dev

  task poll;
    int n;
    n = 0;
    do begin
      dev(11'h000, 1'h0);
      sp();
      n++;
    end while (rsp_ack !== 1'h1 && n < 20);
    cmp_bit(rsp_ack, 1'h1);
  endtask : poll

  task seek(input logic [10:0] a);
    dev(a, 1'h0);
    cmp_bit(rsp_ack, 1'h1);
    wr(a[7:0]);
    cmp_bit(rsp_ack, 1'h1);
  endtask : seek

  task rread(input logic [10:0] a, input int n);
    logic [10:0] p;
    seek(a);
    dev(a, 1'h1);
    cmp_bit(rsp_ack, 1'h1);
    for (int i = 0; i < n; i++) begin
      p = a + i[10:0];
      op(ee_pkg::EE_CMD_READ, 8'hFF, i < n - 1);
      cmp_byte(rsp_data, mem[p]);
    end
    sp();
    // an address-only write must not start programming
    cmp_bit(prog_busy, 1'h0);
  endtask : rread

  task wait_hold_off;
    int n;
    n = 0;
    while (reset_hold !== 1'h0 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_hold_off

  ////////////////////////////////
  initial begin
    repeat (90000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'h0;
    repeat (4) @(posedge ref_clk);
    cmp_bit(bus.sda, 1'h1);
    cmp_bit(prog_busy, 1'h0);
    cmp_bit(reset_hold, 1'h0);
    for (int i = 0; i < 4; i++) begin
      seek(row_a[i]);
      wr(row_d[i]);
      cmp_bit(rsp_ack, 1'h1);
      sp();
      mem[row_a[i]] = row_d[i];
      poll();
      rread(row_a[i], 1);
    end
    rread(11'h7FF, 2);
    // foreign device code must stay unanswered
    dev(11'h100, 1'h0);
    op(ee_pkg::EE_CMD_START, 8'h00, 1'h0);
    wr(8'hB0);
    cmp_bit(rsp_ack, 1'h0);
    sp();
    // seventeen bytes from near page end overrun the page
    seek(11'h3FE);
    for (int i = 0; i < 17; i++) begin
      wr(8'h40 + i[7:0]);
      cmp_bit(rsp_ack, 1'h1);
      mem[{7'h3F, 4'hE + i[3:0]}] = 8'h40 + i[7:0];
    end
    sp();
    dev(11'h000, 1'h0);
    cmp_bit(rsp_ack, 1'h0);
    sp();
    poll();
    cmp_bit(rsp_ack, 1'h1);
    rread(11'h3F0, 15);
    dev(11'h3FF, 1'h1);
    cmp_bit(rsp_ack, 1'h1);
    op(ee_pkg::EE_CMD_READ, 8'hFF, 1'h0);
    cmp_byte(rsp_data, mem[11'h3FF]);
    sp();
    wp_req <= 1'h1;
    seek(11'h2A5);
    wr(8'hEE);
    cmp_bit(rsp_ack, 1'h0);
    sp();
    wp_req <= 1'h0;
    rread(11'h2A5, 1);
    // forced high reset outlives the hold
    mr_hi_req <= 1'h1;
    repeat (20) @(posedge ref_clk);
    cmp_bit(reset_hold, 1'h1);
    dev(11'h000, 1'h0);
    cmp_bit(rsp_ack, 1'h0);
    sp();
    wait_hold_off();
    repeat (20) @(posedge ref_clk);
    cmp_bit(reset_hold, 1'h0);
    dev(11'h000, 1'h0);
    cmp_bit(rsp_ack, 1'h0);
    sp();
    mr_hi_req <= 1'h0;
    repeat (20) @(posedge ref_clk);
    dev(11'h000, 1'h0);
    cmp_bit(rsp_ack, 1'h1);
    sp();
    mr_lo_req <= 1'h1;
    repeat (20) @(posedge ref_clk);
    cmp_bit(reset_hold, 1'h1);
    mr_lo_req <= 1'h0;
    wait_hold_off();
    cmp_bit(reset_hold, 1'h0);
    cmp_num(rsp_n, byte_n);
    end_of_test();
  end
endmodule : ee_test
